// ===== wake_on_lan_pkg.sv
// Constants for the wake-on-LAN configuration and wake output block.
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package wake_on_lan_pkg;

	// Register addresses.
	localparam logic [15:0] ADDR_CONFIG = 16'h0134;
	localparam logic [15:0] ADDR_STATUS = 16'h0135;
	localparam logic [15:0] ADDR_DEST_MATCH = 16'h0136;
	localparam logic [15:0] ADDR_PASSWORD = 16'h0139;
	localparam logic [15:0] ADDR_PATTERN = 16'h013C;
	localparam logic [15:0] ADDR_PATTERN_MASK = 16'h0141;
	localparam logic [15:0] ADDR_INT_STATUS = 16'h0142;
	localparam logic [15:0] ADDR_INT_MASK = 16'h0143;

	localparam int MATCH_WORDS = 3;
	localparam int PATTERN_WORDS = 5;

	// Configuration register fields.
	localparam int CFG_CLEAR = 11;
	localparam int CFG_LEN_LO = 9;
	localparam int CFG_STYLE = 8;
	localparam int CFG_FEATURE = 7;
	localparam int CFG_PWD_EN = 5;
	localparam int CFG_UCAST_EN = 4;
	localparam int CFG_BCAST_EN = 2;
	localparam int CFG_PATTERN_EN = 1;
	localparam int CFG_MAGIC_EN = 0;
	localparam logic [15:0] CONFIG_RESET = 16'h0004;

	// Receive status flag positions.
	localparam int ST_MAGIC = 0;
	localparam int ST_PATTERN = 1;
	localparam int ST_BCAST = 2;
	localparam int ST_UCAST = 4;
	localparam int ST_ATTACK = 5;
	localparam int ST_BAD_CRC = 6;
	localparam int ST_FRAME_DELIMITER_ERROR_SEEN = 7;

	// Interrupt status bits.
	localparam int INT_WAKE = 0;
	localparam int INT_ATTACK = 1;
	localparam int INT_BAD_CRC = 2;
	localparam int INT_FRAME_DELIMITER_ERROR_SEEN = 3;
	localparam int INT_BITS = 4;

	// Pulse length: base of 8 cycles of the 100 MHz clock, doubled per field step.
	localparam logic [6:0] PULSE_BASE_CYCLES = 7'h08;

endpackage : wake_on_lan_pkg

// ===== wake_on_lan_config.sv
// Wake-on-LAN configuration registers, frame event checks and wake output.
`timescale 1ns/1ps

module wake_on_lan_config #(
	parameter int PATTERN_WORDS = wake_on_lan_pkg::PATTERN_WORDS
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Register port
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// Receive frame events from the receive path
	input wire logic rx_frame_end,
	input wire logic rx_crc_bad,
	input wire logic rx_sfd_error,
	input wire logic [47:0] rx_dest_addr,
	input wire logic [PATTERN_WORDS*16-1:0] rx_head_bytes,
	input wire logic rx_magic_found,
	input wire logic [47:0] rx_magic_password,
	// Outputs
	output logic rx_feature_active,
	output logic wake_out,
	output logic irq
);

	localparam int PATTERN_BYTES = PATTERN_WORDS * 2;

	typedef struct packed {
		logic [1:0] pulse_len;
		logic level_style;
		logic feature;
		logic pwd_en;
		logic ucast_en;
		logic bcast_en;
		logic pattern_en;
		logic magic_en;
		logic [7:0] rx_status;
		logic [wake_on_lan_pkg::MATCH_WORDS-1:0][15:0] dest_match;
		logic [wake_on_lan_pkg::MATCH_WORDS-1:0][15:0] password;
		logic [PATTERN_WORDS-1:0][15:0] pattern;
		logic [PATTERN_BYTES-1:0] byte_mask;
		logic [wake_on_lan_pkg::INT_BITS-1:0] int_status;
		logic [wake_on_lan_pkg::INT_BITS-1:0] int_mask;
		logic wake;
		logic [6:0] pulse_left;
		logic irq;
		logic [15:0] rdata;
	} state_type;

	state_type s_q;
	state_type s_d;

	//----------------------------------------------------------------------
	// Frame checks
	//----------------------------------------------------------------------

	logic [PATTERN_BYTES-1:0] byte_hit;

	genvar gi;
	generate
		for (gi = 0; gi < PATTERN_BYTES; gi++)
		begin : g_byte
			// A masked byte always counts as a hit.
			assign byte_hit[gi] = s_q.byte_mask[gi] ||
				(rx_head_bytes[gi*8 +: 8] == s_q.pattern[gi/2][(gi%2)*8 +: 8]);
		end
	endgenerate

	logic frame_ok;
	logic is_bcast;
	logic is_ucast;
	logic pattern_hit;
	logic pwd_ok;
	logic magic_ok;
	logic attack;
	logic bad_crc;
	logic frame_delimiter_error_seen;
	logic wake_event;
	logic clear_write;
	logic [6:0] pulse_cycles;

	always_comb
	begin
		// CRC checking and all detection only run with the feature bit set.
		frame_ok = s_q.feature && rx_frame_end && !rx_crc_bad;
		is_bcast = rx_dest_addr == 48'hFFFF_FFFF_FFFF;
		is_ucast = !is_bcast && (rx_dest_addr == s_q.dest_match);
		// A fully masked pattern would match every frame, so it never hits.
		pattern_hit = (&byte_hit) && !(&s_q.byte_mask);
		pwd_ok = !s_q.pwd_en || (rx_magic_password == s_q.password);
		magic_ok = frame_ok && rx_magic_found && pwd_ok;
		attack = frame_ok && rx_magic_found && !pwd_ok;
		bad_crc = s_q.feature && rx_frame_end && rx_crc_bad;
		frame_delimiter_error_seen = s_q.feature && rx_sfd_error;
		wake_event = (magic_ok && s_q.magic_en)
			|| (frame_ok && pattern_hit && s_q.pattern_en)
			|| (frame_ok && is_bcast && s_q.bcast_en)
			|| (frame_ok && is_ucast && s_q.ucast_en);
		clear_write = reg_write && (reg_addr == wake_on_lan_pkg::ADDR_CONFIG)
			&& reg_wdata[wake_on_lan_pkg::CFG_CLEAR];
		pulse_cycles = wake_on_lan_pkg::PULSE_BASE_CYCLES << s_q.pulse_len;
	end

	//----------------------------------------------------------------------
	// Next state
	//----------------------------------------------------------------------

	always_comb
	begin
		s_d = s_q;
		s_d.rdata = 16'h0000;

		// Register writes.
		if (reg_write)
		begin
			case (reg_addr)
				wake_on_lan_pkg::ADDR_CONFIG:
				begin
					// Clear bit and reserved bits are not stored.
					s_d.pulse_len = reg_wdata[wake_on_lan_pkg::CFG_LEN_LO +: 2];
					s_d.level_style = reg_wdata[wake_on_lan_pkg::CFG_STYLE];
					s_d.feature = reg_wdata[wake_on_lan_pkg::CFG_FEATURE];
					s_d.pwd_en = reg_wdata[wake_on_lan_pkg::CFG_PWD_EN];
					s_d.ucast_en = reg_wdata[wake_on_lan_pkg::CFG_UCAST_EN];
					s_d.bcast_en = reg_wdata[wake_on_lan_pkg::CFG_BCAST_EN];
					s_d.pattern_en = reg_wdata[wake_on_lan_pkg::CFG_PATTERN_EN];
					s_d.magic_en = reg_wdata[wake_on_lan_pkg::CFG_MAGIC_EN];
				end
				wake_on_lan_pkg::ADDR_PATTERN_MASK:
					s_d.byte_mask = reg_wdata[PATTERN_BYTES-1:0];
				wake_on_lan_pkg::ADDR_INT_STATUS:
					s_d.int_status = s_q.int_status & ~reg_wdata[wake_on_lan_pkg::INT_BITS-1:0];
				wake_on_lan_pkg::ADDR_INT_MASK:
					s_d.int_mask = reg_wdata[wake_on_lan_pkg::INT_BITS-1:0];
				default:
				begin
				end
			endcase
			for (int i = 0; i < wake_on_lan_pkg::MATCH_WORDS; i++)
			begin
				if (reg_addr == wake_on_lan_pkg::ADDR_DEST_MATCH + 16'(i))
					s_d.dest_match[i] = reg_wdata;
				if (reg_addr == wake_on_lan_pkg::ADDR_PASSWORD + 16'(i))
					s_d.password[i] = reg_wdata;
			end
			for (int i = 0; i < PATTERN_WORDS; i++)
			begin
				if (reg_addr == wake_on_lan_pkg::ADDR_PATTERN + 16'(i))
					s_d.pattern[i] = reg_wdata;
			end
		end

		// Register reads; unmapped addresses return zero.
		if (reg_read)
		begin
			case (reg_addr)
				wake_on_lan_pkg::ADDR_CONFIG:
				begin
					s_d.rdata[wake_on_lan_pkg::CFG_LEN_LO +: 2] = s_q.pulse_len;
					s_d.rdata[wake_on_lan_pkg::CFG_STYLE] = s_q.level_style;
					s_d.rdata[wake_on_lan_pkg::CFG_FEATURE] = s_q.feature;
					s_d.rdata[wake_on_lan_pkg::CFG_PWD_EN] = s_q.pwd_en;
					s_d.rdata[wake_on_lan_pkg::CFG_UCAST_EN] = s_q.ucast_en;
					s_d.rdata[wake_on_lan_pkg::CFG_BCAST_EN] = s_q.bcast_en;
					s_d.rdata[wake_on_lan_pkg::CFG_PATTERN_EN] = s_q.pattern_en;
					s_d.rdata[wake_on_lan_pkg::CFG_MAGIC_EN] = s_q.magic_en;
				end
				wake_on_lan_pkg::ADDR_STATUS:
					s_d.rdata[7:0] = s_q.rx_status;
				wake_on_lan_pkg::ADDR_PATTERN_MASK:
					s_d.rdata[PATTERN_BYTES-1:0] = s_q.byte_mask;
				wake_on_lan_pkg::ADDR_INT_STATUS:
					s_d.rdata[wake_on_lan_pkg::INT_BITS-1:0] = s_q.int_status;
				wake_on_lan_pkg::ADDR_INT_MASK:
					s_d.rdata[wake_on_lan_pkg::INT_BITS-1:0] = s_q.int_mask;
				default:
				begin
				end
			endcase
			for (int i = 0; i < wake_on_lan_pkg::MATCH_WORDS; i++)
			begin
				if (reg_addr == wake_on_lan_pkg::ADDR_DEST_MATCH + 16'(i))
					s_d.rdata = s_q.dest_match[i];
				if (reg_addr == wake_on_lan_pkg::ADDR_PASSWORD + 16'(i))
					s_d.rdata = s_q.password[i];
			end
			for (int i = 0; i < PATTERN_WORDS; i++)
			begin
				if (reg_addr == wake_on_lan_pkg::ADDR_PATTERN + 16'(i))
					s_d.rdata = s_q.pattern[i];
			end
			// Reading the receive status clears it.
			if (reg_addr == wake_on_lan_pkg::ADDR_STATUS)
				s_d.rx_status = 8'h00;
		end

		// Event flags are set after any clear so that a new event is never lost.
		s_d.rx_status[wake_on_lan_pkg::ST_MAGIC] = s_d.rx_status[wake_on_lan_pkg::ST_MAGIC] | magic_ok;
		s_d.rx_status[wake_on_lan_pkg::ST_PATTERN] = s_d.rx_status[wake_on_lan_pkg::ST_PATTERN]
			| (frame_ok && pattern_hit);
		s_d.rx_status[wake_on_lan_pkg::ST_BCAST] = s_d.rx_status[wake_on_lan_pkg::ST_BCAST]
			| (frame_ok && is_bcast);
		s_d.rx_status[wake_on_lan_pkg::ST_UCAST] = s_d.rx_status[wake_on_lan_pkg::ST_UCAST]
			| (frame_ok && is_ucast);
		s_d.rx_status[wake_on_lan_pkg::ST_ATTACK] = s_d.rx_status[wake_on_lan_pkg::ST_ATTACK] | attack;
		s_d.rx_status[wake_on_lan_pkg::ST_BAD_CRC] = s_d.rx_status[wake_on_lan_pkg::ST_BAD_CRC] | bad_crc;
		s_d.rx_status[wake_on_lan_pkg::ST_FRAME_DELIMITER_ERROR_SEEN] = s_d.rx_status[wake_on_lan_pkg::ST_FRAME_DELIMITER_ERROR_SEEN] | frame_delimiter_error_seen;

		s_d.int_status[wake_on_lan_pkg::INT_WAKE] = s_d.int_status[wake_on_lan_pkg::INT_WAKE] | wake_event;
		s_d.int_status[wake_on_lan_pkg::INT_ATTACK] = s_d.int_status[wake_on_lan_pkg::INT_ATTACK] | attack;
		s_d.int_status[wake_on_lan_pkg::INT_BAD_CRC] = s_d.int_status[wake_on_lan_pkg::INT_BAD_CRC] | bad_crc;
		s_d.int_status[wake_on_lan_pkg::INT_FRAME_DELIMITER_ERROR_SEEN] = s_d.int_status[wake_on_lan_pkg::INT_FRAME_DELIMITER_ERROR_SEEN] | frame_delimiter_error_seen;
		s_d.irq = |(s_d.int_status & s_d.int_mask);

		// Wake output. A new event restarts the pulse, so bursts stretch it.
		if (wake_event)
		begin
			s_d.wake = 1'b1;
			s_d.pulse_left = pulse_cycles - 7'h01;
		end
		else if (s_q.level_style)
		begin
			if (clear_write)
				s_d.wake = 1'b0;
		end
		else if (s_q.pulse_left != 7'h00)
			s_d.pulse_left = s_q.pulse_left - 7'h01;
		else
			s_d.wake = 1'b0;
	end

	//----------------------------------------------------------------------
	// State register
	//----------------------------------------------------------------------

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			s_q <= '0;
			s_q.bcast_en <= wake_on_lan_pkg::CONFIG_RESET[wake_on_lan_pkg::CFG_BCAST_EN];
		end
		else
			s_q <= s_d;
	end

	assign reg_rdata = s_q.rdata;
	assign rx_feature_active = s_q.feature;
	assign wake_out = s_q.wake;
	assign irq = s_q.irq;

	//----------------------------------------------------------------------
	// Assertions
	//----------------------------------------------------------------------

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	logic cfg_read;
	logic status_read;
	assign cfg_read = reg_read && (reg_addr == wake_on_lan_pkg::ADDR_CONFIG);
	assign status_read = reg_read && (reg_addr == wake_on_lan_pkg::ADDR_STATUS);

	sequence short_pulse_start;
		wake_event && !s_q.level_style && (s_q.pulse_len == 2'b00);
	endsequence

	sequence quiet_pulse_mode;
		!wake_event && !s_q.level_style;
	endsequence

	chk_pulse_width: assert property (short_pulse_start |=> wake_out [*8])
		else $error("Short wake pulse not held for eight cycles.");

	chk_pulse_end: assert property (short_pulse_start ##1 quiet_pulse_mode [*8] |=> !wake_out)
		else $error("Short wake pulse lasted beyond eight cycles.");

	chk_level_hold: assert property (wake_out && s_q.level_style && !clear_write |=> wake_out)
		else $error("Level wake output dropped without a clear.");

	chk_level_clear: assert property (clear_write && s_q.level_style && !wake_event |=> !wake_out)
		else $error("Clear write did not drop level wake output.");

	chk_clear_reads_zero: assert property (cfg_read |=> reg_rdata[15:11] == 5'h00
		&& reg_rdata[6] == 1'b0 && reg_rdata[3] == 1'b0)
		else $error("Reserved or clear bits read as nonzero.");

	chk_feature_gate: assert property (!s_q.feature |=> !$rose(wake_out)
		&& !$rose(s_q.rx_status[wake_on_lan_pkg::ST_FRAME_DELIMITER_ERROR_SEEN]))
		else $error("Wake or status raised while features disabled.");

	chk_crc_flag: assert property (s_q.feature && rx_frame_end && rx_crc_bad
		|=> s_q.rx_status[wake_on_lan_pkg::ST_BAD_CRC] && s_q.int_status[wake_on_lan_pkg::INT_BAD_CRC])
		else $error("Bad CRC frame not flagged.");

	chk_sfd_flag: assert property (s_q.feature && rx_sfd_error
		|=> s_q.rx_status[wake_on_lan_pkg::ST_FRAME_DELIMITER_ERROR_SEEN] && s_q.int_status[wake_on_lan_pkg::INT_FRAME_DELIMITER_ERROR_SEEN])
		else $error("Frame delimiter error not flagged.");

	chk_bcast_wake: assert property (frame_ok && s_q.bcast_en && is_bcast
		|=> wake_out && s_q.rx_status[wake_on_lan_pkg::ST_BCAST])
		else $error("Broadcast frame did not wake.");

	chk_unicast_flag: assert property (frame_ok && s_q.ucast_en && is_ucast
		|=> wake_out && s_q.int_status[wake_on_lan_pkg::INT_WAKE])
		else $error("Unicast frame did not wake.");

	chk_pattern_wake: assert property (frame_ok && s_q.pattern_en && pattern_hit
		|=> wake_out && s_q.rx_status[wake_on_lan_pkg::ST_PATTERN])
		else $error("Pattern frame did not wake.");

	chk_magic_wake: assert property (magic_ok && s_q.magic_en
		|=> wake_out && s_q.rx_status[wake_on_lan_pkg::ST_MAGIC])
		else $error("Magic frame did not wake.");

	// With every wake enable off, a frame must leave a quiet output quiet.
	chk_disabled_quiet: assert property (frame_ok && !wake_out
		&& !(s_q.magic_en || s_q.pattern_en || s_q.bcast_en || s_q.ucast_en) |=> !wake_out)
		else $error("Wake output rose with all wake enables off.");

	// An older magic flag may still be pending, so only a fresh rise counts as wrong.
	chk_magic_password: assert property (frame_ok && rx_magic_found && s_q.pwd_en
		&& rx_magic_password != s_q.password |=> s_q.rx_status[wake_on_lan_pkg::ST_ATTACK]
		&& !$rose(s_q.rx_status[wake_on_lan_pkg::ST_MAGIC]))
		else $error("Password mismatch not reported as attack.");

	chk_long_pulse: assert property (wake_event && !s_q.level_style && s_q.pulse_len == 2'b11
		|=> wake_out && s_q.pulse_left == 7'h3F)
		else $error("Longest wake pulse not loaded for sixty-four cycles.");

	chk_status_read_clear: assert property (status_read && !rx_frame_end && !rx_sfd_error
		|=> s_q.rx_status == 8'h00 ##1 (reg_rdata == 16'h0000 || $past(reg_read)))
		else $error("Receive status not cleared by read.");

	chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 16'h0000)
		else $error("Read data not zero outside a read answer.");

	chk_irq_level: assert property (irq == |(s_q.int_status & s_q.int_mask))
		else $error("Interrupt output disagrees with masked status.");

endmodule : wake_on_lan_config

// ===== wake_host_model.sv
// Host-side model that receives the wake output and measures each pulse.
`timescale 1ns/1ps

module wake_host_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Wake line from the device
	input wire logic wake_out,
	// Measured pulse
	output logic [7:0] pulse_len,
	output logic pulse_done
);
	logic [7:0] count_q;

	// A pulse is reported only when the line drops, so a level that is never cleared is never reported.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			count_q <= 8'h00;
			pulse_len <= 8'h00;
			pulse_done <= 1'b0;
		end
		else
		begin
			pulse_done <= 1'b0;
			if (wake_out === 1'b1)
				count_q <= count_q + 8'h01;
			else if (count_q != 8'h00)
			begin
				pulse_len <= count_q;
				pulse_done <= 1'b1;
				count_q <= 8'h00;
			end
		end
	end
endmodule : wake_host_model

// ===== wake_on_lan_config_test.sv
// Self-checking bench for the wake-on-LAN configuration block.
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin miscompares++; \
	$display("MISMATCH %s expected %h seen %h", nm, ex, got); end end

module wake_on_lan_config_test;
	localparam logic [15:0] CFG = wake_on_lan_pkg::ADDR_CONFIG;
	localparam logic [15:0] STS = wake_on_lan_pkg::ADDR_STATUS;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [15:0] reg_rdata;
	logic rx_frame_end = 1'b0;
	logic rx_crc_bad = 1'b0;
	logic rx_sfd_error = 1'b0;
	logic [47:0] rx_dest_addr = 48'h0;
	logic [79:0] rx_head_bytes = 80'h0;
	logic rx_magic_found = 1'b0;
	logic [47:0] rx_magic_password = 48'h0;
	logic rx_feature_active;
	logic wake_out;
	logic irq;
	logic [7:0] pulse_len;
	logic pulse_done;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [31:0] rd_q[$];
	logic [7:0] pulse_q[$];
	logic rd_prev = 1'b0;
	logic [47:0] da;
	logic [47:0] pw;
	logic [47:0] bc;
	logic [79:0] pat;

	always #5 clk_sys = ~clk_sys;

	wake_on_lan_config dut_u (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .rx_frame_end(rx_frame_end),
		.rx_crc_bad(rx_crc_bad), .rx_sfd_error(rx_sfd_error), .rx_dest_addr(rx_dest_addr),
		.rx_head_bytes(rx_head_bytes), .rx_magic_found(rx_magic_found), .rx_magic_password(rx_magic_password),
		.rx_feature_active(rx_feature_active), .wake_out(wake_out), .irq(irq));

	wake_host_model host_u (.clk_sys(clk_sys), .resetn(resetn), .wake_out(wake_out), .pulse_len(pulse_len),
		.pulse_done(pulse_done));

	//----------------------------------------------------------------------
	// Result watcher
	//----------------------------------------------------------------------
	// Sampling on the falling edge keeps the comparison clear of the launching edge.
	always @(negedge clk_sys)
	begin
		logic [31:0] e;
		logic [7:0] p;
		if (rd_prev)
		begin
			e = rd_q.pop_front();
			`CHK("read data", e[15:0], reg_rdata & e[31:16])
		end
		rd_prev = reg_read;
		if (pulse_done)
		begin
			p = (pulse_q.size() == 0) ? 8'h00 : pulse_q.pop_front();
			`CHK("wake pulse length", p, pulse_len)
		end
	end

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			summarize();
		end
	end

	//----------------------------------------------------------------------
	// Drivers
	//----------------------------------------------------------------------
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
		rd_q.push_back({m, e & m});
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
	endtask : rd

	task automatic frame(input logic [47:0] d, input logic m, input logic [47:0] p, input logic [79:0] h,
		input logic [7:0] n, input int gap);
		if (n != 8'h00)
			pulse_q.push_back(n);
		@(posedge clk_sys);
		rx_dest_addr <= d;
		rx_magic_found <= m;
		rx_magic_password <= p;
		rx_head_bytes <= h;
		rx_frame_end <= 1'b1;
		@(posedge clk_sys);
		rx_frame_end <= 1'b0;
		repeat (gap) @(posedge clk_sys);
	endtask : frame

	task automatic note(input string s);
		$display("test %s finished", s);
	endtask : note

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	//----------------------------------------------------------------------
	// Main sequence
	//----------------------------------------------------------------------
	initial
	begin
		void'($urandom(39));
		bc = 48'hFFFFFFFFFFFF;
		da = 48'({$urandom(), $urandom()});
		da[0] = 1'b0;
		pw = 48'({$urandom(), $urandom()});
		pat = 80'({$urandom(), $urandom(), $urandom()});
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(CFG, 16'hFFFF, 16'h0004);
		rd(16'h0150, 16'hFFFF, 16'h0000);
		wr(CFG, 16'hFFFF);
		rd(CFG, 16'hFFFF, 16'h07B7);
		`CHK("feature output", 1'b1, rx_feature_active)
		note("register map");
		wr(CFG, 16'h0004);
		frame(bc, 1'b0, 48'h0, pat, 8'h00, 80);
		rd(STS, 16'hFFFF, 16'h0000);
		for (int l = 0; l < 4; l++)
		begin
			wr(CFG, 16'h0084 | 16'(l << 9));
			frame(bc, 1'b0, 48'h0, pat, 8'(8 << l), 80);
			rd(STS, 16'h0004, 16'h0004);
			rd(STS, 16'h0004, 16'h0000);
		end
		wr(CFG, 16'h0080);
		frame(bc, 1'b0, 48'h0, pat, 8'h00, 80);
		rd(STS, 16'h0044, 16'h0004);
		wr(CFG, 16'h0084);
		rx_crc_bad <= 1'b1;
		frame(bc, 1'b0, 48'h0, pat, 8'h00, 80);
		rx_crc_bad <= 1'b0;
		rd(STS, 16'h0044, 16'h0040);
		rx_sfd_error <= 1'b1;
		@(posedge clk_sys);
		rx_sfd_error <= 1'b0;
		rd(STS, 16'h00C4, 16'h0080);
		note("pulse and broadcast");
		for (int i = 0; i < 3; i++)
			wr(wake_on_lan_pkg::ADDR_DEST_MATCH + 16'(i), da[16*i +: 16]);
		wr(CFG, 16'h0080);
		frame(da, 1'b0, 48'h0, pat, 8'h00, 80);
		wr(CFG, 16'h0090);
		frame(da, 1'b0, 48'h0, pat, 8'h08, 80);
		note("unicast");
		for (int i = 0; i < 3; i++)
			wr(wake_on_lan_pkg::ADDR_PASSWORD + 16'(i), pw[16*i +: 16]);
		wr(CFG, 16'h0080);
		frame(bc, 1'b1, ~pw, pat, 8'h00, 80);
		wr(CFG, 16'h0081);
		frame(bc, 1'b1, ~pw, pat, 8'h08, 80);
		rd(STS, 16'h0021, 16'h0001);
		wr(CFG, 16'h00A1);
		frame(bc, 1'b1, ~pw, pat, 8'h00, 80);
		rd(STS, 16'h0021, 16'h0020);
		frame(bc, 1'b1, pw, pat, 8'h08, 80);
		rd(STS, 16'h0021, 16'h0001);
		note("magic packet");
		for (int i = 0; i < 5; i++)
			wr(wake_on_lan_pkg::ADDR_PATTERN + 16'(i), pat[16*i +: 16]);
		wr(wake_on_lan_pkg::ADDR_PATTERN_MASK, 16'h0001);
		wr(CFG, 16'h0082);
		frame(bc, 1'b0, 48'h0, pat ^ 80'hFF, 8'h08, 80);
		frame(bc, 1'b0, 48'h0, pat ^ 80'hFF00, 8'h00, 80);
		note("pattern");
		wr(wake_on_lan_pkg::ADDR_INT_MASK, 16'h0000);
		wr(wake_on_lan_pkg::ADDR_INT_STATUS, 16'h000F);
		wr(CFG, 16'h0184);
		frame(bc, 1'b0, 48'h0, pat, 8'd22, 20);
		#1;
		`CHK("wake level held", 1'b1, wake_out)
		`CHK("masked interrupt", 1'b0, irq)
		wr(CFG, 16'h0984);
		rd(CFG, 16'hFFFF, 16'h0184);
		wr(wake_on_lan_pkg::ADDR_INT_MASK, 16'h0001);
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("unmasked interrupt", 1'b1, irq)
		wr(wake_on_lan_pkg::ADDR_INT_STATUS, 16'h0001);
		repeat (2) @(posedge clk_sys);
		#1;
		`CHK("cleared interrupt", 1'b0, irq)
		note("level and interrupt");
		repeat (10) @(posedge clk_sys);
		`CHK("pending pulses", 32'h0, 32'(pulse_q.size()))
		summarize();
	end
endmodule : wake_on_lan_config_test
